// [rtl/bpwm_defines.svh]
`ifndef BPWM_DEFINES_SVH
`define BPWM_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BPWM_OFS_SHDN_CTRL 8'h00
`define BPWM_OFS_PWM_CTRL 8'h04
`define BPWM_OFS_CAP_CTRL 8'h08
`define BPWM_OFS_AUX_CTRL 8'h0C
`define BPWM_OFS_STATE 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BPWM_SHDN_STATUS_BIT 7
`define BPWM_SHDN_SRC_MSB 6
`define BPWM_SHDN_SRC_LSB 4
`define BPWM_SHDN_AC_MSB 3
`define BPWM_SHDN_AC_LSB 2
`define BPWM_SHDN_BD_MSB 1
`define BPWM_SHDN_BD_LSB 0
`define BPWM_PWM_RESTART_BIT 7
`define BPWM_PWM_DEAD_MSB 6
`define BPWM_PWM_DEAD_LSB 0
`define BPWM_CAP_MODE_MSB 7
`define BPWM_CAP_MODE_LSB 6
`define BPWM_CAP_ENABLE_BIT 2
`define BPWM_CAP_POL_MSB 1
`define BPWM_CAP_POL_LSB 0
`define BPWM_AUX_COMPARATOR_TWO_SYNC_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BPWM_RST_SHDN_CTRL 8'h00
`define BPWM_RST_PWM_CTRL 8'h00
`define BPWM_RST_CAP_CTRL 8'h00
`define BPWM_RST_AUX_CTRL 8'h00

`endif

// [rtl/bpwm_pkg.sv]
package bpwm_pkg;

	// ----------------------------------------
	// Output modes, one-hot
	// ----------------------------------------
	typedef enum logic [3:0] {
		BPWM_SINGLE = 4'h1,
		BPWM_HALF = 4'h2,
		BPWM_FWD = 4'h4,
		BPWM_REV = 4'h8
	} bpwm_mode_e;

	typedef logic [7:0] bpwm_byte_t;

endpackage : bpwm_pkg

// [rtl/bpwm_dead_band.sv]
// ----------------------------------------
// Rising-edge delay counted in instruction ticks
// ----------------------------------------
module bpwm_dead_band (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_i,
	input wire logic tick_i,
	input wire logic [6:0] count_i,
	output logic out_o
);

	logic [6:0] cnt;
	wire reached;

	assign reached = (cnt >= count_i);

	// Input falling first keeps output low all cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || !in_i) begin
			cnt <= 7'h00;
			out_o <= 1'h0;
		end else if (reached) begin
			out_o <= 1'h1;
		end else if (tick_i) begin
			cnt <= cnt + 7'h01;
		end
	end

endmodule : bpwm_dead_band

// [rtl/bpwm_output_stage.sv]
`include "bpwm_defines.svh"

module bpwm_output_stage (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pwm_raw_i,
	input wire logic period_start_i,
	input wire logic tcy_tick_i,
	input wire logic t1_sync_tick_i,
	input wire logic comparator_one_i,
	input wire logic comparator_two_i,
	input wire logic int_pin_i,
	output logic out_a_o,
	output logic out_a_oe_o,
	output logic out_b_o,
	output logic out_b_oe_o,
	output logic out_c_o,
	output logic out_c_oe_o,
	output logic out_d_o,
	output logic out_d_oe_o
);

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	function automatic bpwm_pkg::bpwm_mode_e bpwm_decode_mode(input logic [1:0] sel);
		bpwm_pkg::bpwm_mode_e m;
		m = bpwm_pkg::BPWM_SINGLE;
		unique case (sel)
			2'h0: m = bpwm_pkg::BPWM_SINGLE;
			2'h2: m = bpwm_pkg::BPWM_HALF;
			2'h1: m = bpwm_pkg::BPWM_FWD;
			2'h3: m = bpwm_pkg::BPWM_REV;
		endcase
		return m;
	endfunction : bpwm_decode_mode

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic shutdown_status;
	logic [2:0] shutdown_source_select;
	logic [1:0] pair_ac_shutdown_state;
	logic [1:0] pair_bd_shutdown_state;
	logic auto_restart_enable;
	logic [6:0] dead_band_count;
	logic [1:0] bridge_mode_select;
	logic pwm_enable;
	logic [1:0] polarity_select;
	logic comparator_two_sync;
	logic comparator_two_q;
	logic dir_applied;
	logic changing;
	logic running;
	logic shut_hold;
	logic [3:0] pin_lvl;
	logic [3:0] pin_oe;
	logic [1:0] db_out;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire bus_req;
	wire bus_wr;
	wire wr_shdn;
	wire wr_pwm;
	wire wr_cap;
	wire wr_aux;
	wire [7:0] wd;
	logic [7:0] rd_mux;

	assign bus_req = wb_cyc_i && wb_stb_i;
	// Writes land on the edge where the master sees ack
	assign bus_wr = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
	assign wr_shdn = bus_wr && (wb_adr_i == `BPWM_OFS_SHDN_CTRL);
	assign wr_pwm = bus_wr && (wb_adr_i == `BPWM_OFS_PWM_CTRL);
	assign wr_cap = bus_wr && (wb_adr_i == `BPWM_OFS_CAP_CTRL);
	assign wr_aux = bus_wr && (wb_adr_i == `BPWM_OFS_AUX_CTRL);
	assign wd = wb_dat_i[7:0];

	// ----------------------------------------
	// Shutdown sources
	// ----------------------------------------
	wire int_low;
	wire cond;
	wire wr_status_one;
	wire wr_status_zero;
	wire hw_restart;
	wire next_status;

	assign int_low = !int_pin_i;
	assign cond = (shutdown_source_select[0] && comparator_one_i)
		|| (shutdown_source_select[1] && comparator_two_q)
		|| (shutdown_source_select[2] && int_low);
	assign wr_status_one = wr_shdn && wd[`BPWM_SHDN_STATUS_BIT];
	assign wr_status_zero = wr_shdn && !wd[`BPWM_SHDN_STATUS_BIT] && !cond;
	assign hw_restart = auto_restart_enable && !cond;
	// Firmware set; set wins over clear
	assign next_status = cond || wr_status_one
		|| (shutdown_status && !wr_status_zero && !hw_restart);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			comparator_two_q <= 1'h0;
		end else if (!comparator_two_sync || t1_sync_tick_i) begin
			comparator_two_q <= comparator_two_i;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{shutdown_status, shutdown_source_select, pair_ac_shutdown_state, pair_bd_shutdown_state}
				<= `BPWM_RST_SHDN_CTRL;
			{auto_restart_enable, dead_band_count} <= `BPWM_RST_PWM_CTRL;
			comparator_two_sync <= 1'h0;
		end else begin
			shutdown_status <= next_status;
			if (wr_shdn) begin
				shutdown_source_select <= wd[`BPWM_SHDN_SRC_MSB:`BPWM_SHDN_SRC_LSB];
				pair_ac_shutdown_state <= wd[`BPWM_SHDN_AC_MSB:`BPWM_SHDN_AC_LSB];
				pair_bd_shutdown_state <= wd[`BPWM_SHDN_BD_MSB:`BPWM_SHDN_BD_LSB];
			end
			if (wr_pwm) begin
				auto_restart_enable <= wd[`BPWM_PWM_RESTART_BIT];
				dead_band_count <= wd[`BPWM_PWM_DEAD_MSB:`BPWM_PWM_DEAD_LSB];
			end
			if (wr_aux) begin
				comparator_two_sync <= wd[`BPWM_AUX_COMPARATOR_TWO_SYNC_BIT];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bridge_mode_select <= 2'h0;
			pwm_enable <= 1'h0;
			polarity_select <= 2'h0;
		end else if (wr_cap) begin
			bridge_mode_select <= wd[`BPWM_CAP_MODE_MSB:`BPWM_CAP_MODE_LSB];
			pwm_enable <= wd[`BPWM_CAP_ENABLE_BIT];
			polarity_select <= wd[`BPWM_CAP_POL_MSB:`BPWM_CAP_POL_LSB];
		end
	end

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	always_comb begin
		rd_mux = 8'h00;
		unique case (wb_adr_i)
			`BPWM_OFS_SHDN_CTRL: rd_mux = {shutdown_status, shutdown_source_select,
				pair_ac_shutdown_state, pair_bd_shutdown_state};
			`BPWM_OFS_PWM_CTRL: rd_mux = {auto_restart_enable, dead_band_count};
			`BPWM_OFS_CAP_CTRL: rd_mux = {bridge_mode_select, 3'h0, pwm_enable, polarity_select};
			`BPWM_OFS_AUX_CTRL: rd_mux = {7'h00, comparator_two_sync};
			`BPWM_OFS_STATE: rd_mux = {running, shut_hold, dir_applied, cond, pin_lvl};
			default: rd_mux = 8'h00;
		endcase
	end

	// Unmapped addresses still ack, reading zero, so the master never hangs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'h0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req && !wb_ack_o;
			wb_dat_o <= {24'h00_0000, rd_mux};
		end
	end

	// ----------------------------------------
	// Direction and period sequencing
	// ----------------------------------------
	wire full_bridge;
	wire dir_flip;
	bpwm_pkg::bpwm_mode_e mode;

	assign full_bridge = bridge_mode_select[0];
	assign dir_flip = full_bridge && (bridge_mode_select[1] != dir_applied);
	// Mode decode, full-bridge direction from the applied copy
	assign mode = bpwm_decode_mode(full_bridge ? {dir_applied, 1'h1} : bridge_mode_select);

	// Swap unmodulated now, modulate again at next period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_applied <= 1'h0;
			changing <= 1'h0;
		end else begin
			dir_applied <= bridge_mode_select[1];
			if (dir_flip) begin
				changing <= 1'h1;
			end else if (period_start_i || !full_bridge) begin
				changing <= 1'h0;
			end
		end
	end

	// Waiting for a period start avoids a truncated first pulse
	// Shutdown hold released only at a period start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			running <= 1'h0;
			shut_hold <= 1'h0;
		end else begin
			if (!pwm_enable) begin
				running <= 1'h0;
			end else if (period_start_i) begin
				running <= 1'h1;
			end
			if (shutdown_status) begin
				shut_hold <= 1'h1;
			end else if (period_start_i) begin
				shut_hold <= 1'h0;
			end
		end
	end

	// ----------------------------------------
	// Logical output levels
	// ----------------------------------------
	wire [1:0] db_in;
	logic [3:0] lvl;

	assign db_in = {!pwm_raw_i && (mode == bpwm_pkg::BPWM_HALF), pwm_raw_i && (mode == bpwm_pkg::BPWM_HALF)};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_db
			bpwm_dead_band u_db (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.in_i(db_in[gi]),
				.tick_i(tcy_tick_i),
				.count_i(dead_band_count),
				.out_o(db_out[gi])
			);
		end
	endgenerate

	// Bit order d, c, b, a
	always_comb begin
		lvl = 4'h0;
		unique case (mode)
			// Steering is not modelled: single mode drives A only
			bpwm_pkg::BPWM_SINGLE: lvl = {3'h0, pwm_raw_i};
			bpwm_pkg::BPWM_HALF: lvl = {2'h0, db_out[1], db_out[0]};
			bpwm_pkg::BPWM_FWD: lvl = {pwm_raw_i && !changing, 2'h0, 1'h1};
			bpwm_pkg::BPWM_REV: lvl = {1'h0, 1'h1, pwm_raw_i && !changing, 1'h0};
		endcase
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	wire shut;
	wire drive;
	wire [3:0] pin_used;

	assign shut = shutdown_status || shut_hold;
	assign drive = pwm_enable && running;
	// Pins outside the mode stay released so they remain free for other uses
	assign pin_used = (mode == bpwm_pkg::BPWM_SINGLE) ? 4'h1 : (mode == bpwm_pkg::BPWM_HALF) ? 4'h3 : 4'hF;

	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			wire [1:0] pss;
			wire pol_low;
			assign pss = (gi % 2 == 0) ? pair_ac_shutdown_state : pair_bd_shutdown_state;
			assign pol_low = (gi % 2 == 0) ? polarity_select[1] : polarity_select[0];
			// Pair polarity; shutdown state, next edge
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pin_lvl[gi] <= 1'h0;
					pin_oe[gi] <= 1'h0;
				end else begin
					pin_lvl[gi] <= shut ? pss[0] : (lvl[gi] ^ pol_low);
					pin_oe[gi] <= drive && pin_used[gi] && !(shut && pss[1]);
				end
			end
		end
	endgenerate

	assign out_a_o = pin_lvl[0];
	assign out_b_o = pin_lvl[1];
	assign out_c_o = pin_lvl[2];
	assign out_d_o = pin_lvl[3];
	assign out_a_oe_o = pin_oe[0];
	assign out_b_oe_o = pin_oe[1];
	assign out_c_oe_o = pin_oe[2];
	assign out_d_oe_o = pin_oe[3];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_status_set;
		@(posedge clk_i) disable iff (rst_i) (cond || wr_status_one) |=> shutdown_status;
	endproperty
	a_status_set: assert property (p_status_set) else $error("status not set by shutdown event");

	property p_write_blocked;
		@(posedge clk_i) disable iff (rst_i) (shutdown_status && cond) |=> shutdown_status;
	endproperty
	a_write_blocked: assert property (p_write_blocked) else $error("status cleared during condition");

	property p_auto_restart;
		@(posedge clk_i) disable iff (rst_i)
			(shutdown_status && auto_restart_enable && !cond && !wr_status_one) |=> !shutdown_status;
	endproperty
	a_auto_restart: assert property (p_auto_restart) else $error("auto restart did not clear status");

	property p_shut_pins;
		@(posedge clk_i) disable iff (rst_i)
			shutdown_status |=> (out_a_o == $past(pair_ac_shutdown_state[0]))
				&& (out_d_o == $past(pair_bd_shutdown_state[0])) && !(out_b_oe_o && $past(pair_bd_shutdown_state[1]));
	endproperty
	a_shut_pins: assert property (p_shut_pins) else $error("pins not in shutdown state");

	property p_resume_period;
		@(posedge clk_i) disable iff (rst_i) (shut_hold && !shutdown_status && !period_start_i) |=> shut_hold;
	endproperty
	a_resume_period: assert property (p_resume_period) else $error("resumed before period start");

	property p_forward;
		@(posedge clk_i) disable iff (rst_i)
			(mode == bpwm_pkg::BPWM_FWD && !shut) |=> (out_a_o == !$past(polarity_select[1]))
				&& (out_b_o == $past(polarity_select[0])) && (out_d_o == ($past(lvl[3]) ^ $past(polarity_select[0])));
	endproperty
	a_forward: assert property (p_forward) else $error("forward pin levels wrong");

	property p_reverse;
		@(posedge clk_i) disable iff (rst_i)
			(mode == bpwm_pkg::BPWM_REV && !changing) |-> lvl[2] && !lvl[0] && !lvl[3] && (lvl[1] == pwm_raw_i);
	endproperty
	a_reverse: assert property (p_reverse) else $error("reverse levels wrong");

	property p_dir_change;
		@(posedge clk_i) disable iff (rst_i)
			dir_flip |=> changing && !lvl[1] && !lvl[3] && (dir_applied == $past(bridge_mode_select[1]));
	endproperty
	a_dir_change: assert property (p_dir_change) else $error("direction change sequence wrong");

	property p_dead_band;
		@(posedge clk_i) disable iff (rst_i)
			($rose(pwm_raw_i) && mode == bpwm_pkg::BPWM_HALF && dead_band_count >= 7'h02) |=> !db_out[0] [*2];
	endproperty
	a_dead_band: assert property (p_dead_band) else $error("half-bridge rise not delayed");

endmodule : bpwm_output_stage

// [tb/bpwm_switch_model.sv]
// ----------------------------------------
// Power switch drivers of the bridge
// ----------------------------------------
module bpwm_switch_model (
	input wire logic [3:0] pin_i,
	input wire logic [3:0] oe_i,
	output logic [3:0] pad_o,
	output logic shoot_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-downs keep a released gate off, so no stale level survives
	assign pad_o = pin_i & oe_i;
	// Upper and lower switch of one leg on together
	assign shoot_o = (pad_o[0] & pad_o[1]) | (pad_o[2] & pad_o[3]);
endmodule : bpwm_switch_model

// [tb/bpwm_output_stage_tb.sv]
`include "bpwm_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end

module bpwm_output_stage_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 30000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, raw = 1'b0, pst = 1'b0, tick = 1'b1;
	logic t1 = 1'b0, c1 = 1'b0, c2 = 1'b0, intp = 1'b1;
	logic [3:0] sel = 4'hF;
	logic [7:0] adr = 8'h00;
	logic [7:0] e8;
	logic [2:0] sc;
	logic [31:0] wdat = 32'h0, rdat;
	wire logic [31:0] dat_o;
	wire logic ack, shoot;
	wire logic [3:0] pin, oe, pad;
	integer seed = 32'had48, miscompares = 0, tests_run = 0, ncyc = 0, la, lb, l0, lb0;

	bpwm_output_stage i_bpwm_output_stage (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.pwm_raw_i(raw), .period_start_i(pst), .tcy_tick_i(tick), .t1_sync_tick_i(t1), .comparator_one_i(c1),
		.comparator_two_i(c2), .int_pin_i(intp), .out_a_o(pin[0]), .out_a_oe_o(oe[0]), .out_b_o(pin[1]),
		.out_b_oe_o(oe[1]), .out_c_o(pin[2]), .out_c_oe_o(oe[2]), .out_d_o(pin[3]), .out_d_oe_o(oe[3]));
	bpwm_switch_model i_bpwm_switch_model (.pin_i(pin), .oe_i(oe), .pad_o(pad), .shoot_o(shoot));

	// ----------------------------------------
	// Bus and timing helpers
	// ----------------------------------------
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 8'h00);
	endtask : rd

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_n

	task automatic period();
		pst <= 1'b1;
		@(posedge clk_i);
		pst <= 1'b0;
		@(posedge clk_i);
	endtask : period

	// polarity first, drivers after a full cycle
	task automatic cfg(input logic [1:0] m, input logic [1:0] p);
		wb(1'b1, `BPWM_OFS_CAP_CTRL, 8'h00);
		wb(1'b1, `BPWM_OFS_CAP_CTRL, {m, 4'h0, p});
		period();
		period();
		wb(1'b1, `BPWM_OFS_CAP_CTRL, {m, 4'h1, p});
		period();
	endtask : cfg

	task automatic lat(input int i, input logic v, output int n);
		raw <= ~v;
		wait_n(140);
		raw <= v;
		n = 0;
		@(posedge clk_i);
		while (pin[i] !== 1'b1 && n < 300) begin
			n++;
			@(posedge clk_i);
		end
	endtask : lat

	// Expected {enables, pads} for a mode, polarity and raw level
	function automatic logic [7:0] model(input logic [1:0] m, input logic [1:0] p, input logic r);
		logic [3:0] act, en;
		case (m)
			2'b00: begin act = {3'b000, r}; en = 4'h1; end
			2'b10: begin act = {2'b00, ~r, r}; en = 4'h3; end
			2'b01: begin act = {r, 3'b001}; en = 4'hF; end
			default: begin act = {2'b01, r, 1'b0}; en = 4'hF; end
		endcase
		act = act ^ {p[0], p[1], p[0], p[1]};
		return {en, act & en};
	endfunction : model

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		ncyc <= ncyc + 1;
		if (ncyc == LIMIT) begin
			miscompares++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		wait_n(20);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 5; i++) begin
			rd((i < 4) ? 8'(i * 4) : 8'h20);
			`CHK(rdat, 32'h0)
		end
		e8 = 8'($random(seed));
		wb(1'b1, `BPWM_OFS_PWM_CTRL, e8);
		sel <= 4'h0;
		wb(1'b1, `BPWM_OFS_PWM_CTRL, ~e8);
		sel <= 4'hF;
		wb(1'b1, 8'h20, 8'hFF);
		rd(`BPWM_OFS_PWM_CTRL);
		`CHK(rdat, {24'h0, e8})
		rd(8'h20);
		`CHK(rdat, 32'h0)
		wb(1'b1, `BPWM_OFS_PWM_CTRL, 8'h00);
		wb(1'b1, `BPWM_OFS_CAP_CTRL, 8'h44);
		wait_n(4);
		`CHK(oe, 4'h0)
		$display("test registers finished");
		for (int k = 0; k < 16; k++) begin
			cfg(k[3:2], k[1:0]);
			repeat (3) begin
				raw <= 1'($random(seed));
				wait_n(8);
				`CHK({oe, pad}, model(k[3:2], k[1:0], raw))
				if (k[1:0] == 2'b00) `CHK(shoot, 1'b0)
			end
		end
		$display("test modes finished");
		cfg(2'b10, 2'b00);
		lat(0, 1'b1, l0);
		lat(1, 1'b0, lb0);
		for (int j = 0; j < 3; j++) begin
			e8 = (j == 0) ? 8'h01 : (j == 1) ? {2'b00, 6'($random(seed))} + 8'h02 : 8'h7F;
			wb(1'b1, `BPWM_OFS_PWM_CTRL, e8);
			lat(0, 1'b1, la);
			lat(1, 1'b0, lb);
			`CHK(la - l0, int'(e8))
			`CHK(lb - lb0, int'(e8))
		end
		wb(1'b1, `BPWM_OFS_PWM_CTRL, 8'h0A);
		raw <= 1'b0;
		wait_n(140);
		raw <= 1'b1;
		wait_n(5);
		raw <= 1'b0;
		la = 0;
		repeat (30) begin
			@(posedge clk_i);
			if (pin[0] === 1'b1) la++;
		end
		`CHK(la, 0)
		cfg(2'b01, 2'b00);
		wb(1'b1, `BPWM_OFS_PWM_CTRL, 8'h00);
		lat(3, 1'b1, l0);
		wb(1'b1, `BPWM_OFS_PWM_CTRL, 8'h14);
		lat(3, 1'b1, la);
		`CHK(la, l0)
		rd(`BPWM_OFS_STATE);
		`CHK(rdat[7], 1'b1)
		$display("test dead band finished");
		// Reversal below runs with raw held high; the model flags any shoot-through
		for (int j = 0; j < 2; j++) begin
			raw <= 1'b1;
			wait_n(8);
			wb(1'b1, `BPWM_OFS_CAP_CTRL, {(j == 0) ? 2'b11 : 2'b01, 4'h1, 2'b00});
			wait_n(2);
			`CHK({oe, pad}, model((j == 0) ? 2'b11 : 2'b01, 2'b00, 1'b0))
			wait_n(10);
			`CHK({oe, pad}, model((j == 0) ? 2'b11 : 2'b01, 2'b00, 1'b0))
			`CHK(shoot, 1'b0)
			period();
			wait_n(3);
			`CHK({oe, pad}, model((j == 0) ? 2'b11 : 2'b01, 2'b00, 1'b1))
		end
		$display("test direction finished");
		for (int c = 0; c < 8; c++) begin
			for (int t = 0; t < 3; t++) begin
				sc = c[2:0];
				wb(1'b1, `BPWM_OFS_SHDN_CTRL, {1'b0, sc, 4'h4});
				c1 <= (t == 0);
				c2 <= (t == 1);
				intp <= (t != 2);
				wait_n(6);
				e8 = {7'h00, (sc[0] && t == 0) || (sc[1] && t == 1) || (sc[2] && t == 2)};
				rd(`BPWM_OFS_SHDN_CTRL);
				`CHK(rdat[7], e8[0])
				if (e8[0]) begin
					`CHK({oe, pad}, 8'hF5)
					wb(1'b1, `BPWM_OFS_SHDN_CTRL, {1'b0, sc, 4'h4});
					rd(`BPWM_OFS_SHDN_CTRL);
					`CHK(rdat[7], 1'b1)
				end
				c1 <= 1'b0;
				c2 <= 1'b0;
				intp <= 1'b1;
				wait_n(3);
				wb(1'b1, `BPWM_OFS_SHDN_CTRL, {1'b0, sc, 4'h4});
				rd(`BPWM_OFS_SHDN_CTRL);
				`CHK(rdat[7], 1'b0)
				if (e8[0]) `CHK({oe, pad}, 8'hF5)
				period();
				wait_n(3);
				`CHK({oe, pad}, model(2'b01, 2'b00, raw))
			end
		end
		for (int f = 0; f < 4; f++) begin
			wb(1'b1, `BPWM_OFS_SHDN_CTRL, {4'h8, f[1:0], f[1:0]});
			wait_n(3);
			`CHK({oe, pad}, (f == 1) ? 8'hFF : (f == 0) ? 8'hF0 : 8'h00)
			wb(1'b1, `BPWM_OFS_SHDN_CTRL, 8'h00);
			period();
		end
		wb(1'b1, `BPWM_OFS_PWM_CTRL, 8'h80);
		wb(1'b1, `BPWM_OFS_SHDN_CTRL, 8'h10);
		c1 <= 1'b1;
		wait_n(4);
		c1 <= 1'b0;
		wait_n(6);
		rd(`BPWM_OFS_SHDN_CTRL);
		`CHK(rdat[7:0], 8'h10)
		wb(1'b1, `BPWM_OFS_AUX_CTRL, 8'h01);
		wb(1'b1, `BPWM_OFS_SHDN_CTRL, 8'h20);
		c2 <= 1'b1;
		wait_n(10);
		rd(`BPWM_OFS_SHDN_CTRL);
		`CHK(rdat[7], 1'b0)
		t1 <= 1'b1;
		@(posedge clk_i);
		t1 <= 1'b0;
		wait_n(4);
		rd(`BPWM_OFS_SHDN_CTRL);
		`CHK(rdat[7], 1'b1)
		$display("test shutdown finished");
		stop_test();
	end
endmodule : bpwm_output_stage_tb
